// File: rtl/sdbsm_pkg.sv
// shared types and timing constants for the sdram bank state machine
package sdbsm_pkg;
  localparam int CLK_MHZ      = 100;
  localparam int T_RCD_NS     = 20;
  localparam int T_RP_NS      = 20;
  localparam int T_RFC_NS     = 66;
  localparam int T_MRD_CLK    = 2;
  localparam int T_XSR_NS     = 75;
  localparam int BURST_LEN    = 8;
  localparam int BANKS        = 4;
  localparam int CNT_W        = 8;
  localparam int AP_BIT       = 10;
  localparam int ADDR_W       = 13;

  // least times round up to whole cycles, never below one
  function automatic int ns_to_clk(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RCD_CYC = ns_to_clk(T_RCD_NS);
  localparam int RP_CYC  = ns_to_clk(T_RP_NS);
  localparam int RFC_CYC = ns_to_clk(T_RFC_NS);
  localparam int XSR_CYC = ns_to_clk(T_XSR_NS);

  typedef enum logic [2:0] {
    SDBSM_CMD_NOP, SDBSM_CMD_ACT, SDBSM_CMD_RD, SDBSM_CMD_WR,
    SDBSM_CMD_PRE, SDBSM_CMD_BST, SDBSM_CMD_REF, SDBSM_CMD_LMR
  } sdbsm_cmd_t;

  typedef enum logic [2:0] {
    SDBSM_BK_IDLE, SDBSM_BK_ACTIVATING, SDBSM_BK_ACTIVE, SDBSM_BK_READ,
    SDBSM_BK_WRITE, SDBSM_BK_READ_AP, SDBSM_BK_WRITE_AP, SDBSM_BK_PRECHARGING
  } sdbsm_bank_st_t;

  typedef enum logic [1:0] {
    SDBSM_DEV_NORMAL, SDBSM_DEV_REFRESH, SDBSM_DEV_MODE_REG, SDBSM_DEV_PRE_ALL
  } sdbsm_dev_st_t;

  // decoded command as it reaches every bank
  typedef struct packed {
    sdbsm_cmd_t cmd;
    logic [1:0] bank;
    logic       ap;
  } sdbsm_req_t;
endpackage

// File: rtl/sdbsm_bank.sv
// one bank's state and transient-state timer
`timescale 1ns/10ps
`default_nettype none
module sdbsm_bank
  import sdbsm_pkg::*;
#(
  parameter int IDX = 0
) (
  input  wire logic           clk_in,
  input  wire logic           rstn_in,
  input  wire logic           enable_in,
  input  wire sdbsm_req_t     req_in,
  input  wire logic           all_idle_in,
  input  wire logic           bst_hit_in,
  output var sdbsm_bank_st_t  state_out
);
  sdbsm_bank_st_t   st_r;
  logic [CNT_W-1:0] cnt_r;
  logic             mine;
  logic             pre_hit;

  assign mine    = enable_in && (req_in.bank == 2'(IDX));
  // precharge all ignores the bank select inputs
  assign pre_hit = enable_in && (req_in.cmd == SDBSM_CMD_PRE) && (req_in.ap || req_in.bank == 2'(IDX));
  assign state_out = st_r;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r  <= SDBSM_BK_IDLE;
      cnt_r <= '0;
    end else if (all_idle_in) begin
      st_r  <= SDBSM_BK_IDLE;
      cnt_r <= '0;
    end else begin
      if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end
      case (st_r)
        SDBSM_BK_IDLE: begin
          if (mine && req_in.cmd == SDBSM_CMD_ACT) begin
            st_r  <= SDBSM_BK_ACTIVATING;
            cnt_r <= CNT_W'(RCD_CYC - 1);
          end
          // precharge to an idle bank falls through unchanged
        end
        SDBSM_BK_ACTIVATING: begin
          if (cnt_r == '0) begin
            st_r <= SDBSM_BK_ACTIVE;
          end
        end
        SDBSM_BK_ACTIVE, SDBSM_BK_READ, SDBSM_BK_WRITE: begin
          if (pre_hit) begin
            st_r  <= SDBSM_BK_PRECHARGING;
            cnt_r <= CNT_W'(RP_CYC - 1);
          end else if (mine && (req_in.cmd == SDBSM_CMD_RD || req_in.cmd == SDBSM_CMD_WR)) begin
            // new column restarts the burst; both ap variants taken
            if (req_in.ap) begin
              st_r <= (req_in.cmd == SDBSM_CMD_RD) ? SDBSM_BK_READ_AP : SDBSM_BK_WRITE_AP;
              cnt_r <= CNT_W'(BURST_LEN + RP_CYC - 1);
            end else begin
              st_r <= (req_in.cmd == SDBSM_CMD_RD) ? SDBSM_BK_READ : SDBSM_BK_WRITE;
              cnt_r <= CNT_W'(BURST_LEN - 1);
            end
          end else if (bst_hit_in && st_r != SDBSM_BK_ACTIVE) begin
            st_r <= SDBSM_BK_ACTIVE;
          end else if (st_r != SDBSM_BK_ACTIVE && cnt_r == '0) begin
            st_r <= SDBSM_BK_ACTIVE; // fixed burst ran out
          end
        end
        SDBSM_BK_READ_AP, SDBSM_BK_WRITE_AP, SDBSM_BK_PRECHARGING: begin
          // same-bank commands are not expected here; the timer runs on
          if (cnt_r == '0) begin
            st_r <= SDBSM_BK_IDLE;
          end
        end
        default: st_r <= SDBSM_BK_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: rtl/sdbsm_top.sv
// sdram command decoder, device-wide states and four bank machines
`timescale 1ns/10ps
`default_nettype none
module sdbsm_top
  import sdbsm_pkg::*;
#(
  parameter int NBANK = BANKS
) (
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  input  wire logic              cke_in,
  input  wire logic              cs_n_in,
  input  wire logic              ras_n_in,
  input  wire logic              cas_n_in,
  input  wire logic              we_n_in,
  input  wire logic [1:0]        ba_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  output logic [NBANK*3-1:0]     bank_state_out,
  output var sdbsm_dev_st_t      dev_state_out,
  output logic                   all_idle_out,
  output logic                   cmd_error_out
);
  // pins cross in through two flops before decode
  logic [ADDR_W+8-1:0] pin_s1_r;
  logic [ADDR_W+8-1:0] pin_s2_r;
  logic                cke_prev_r;
  logic [CNT_W-1:0]    xsr_cnt_r;
  logic [CNT_W-1:0]    dev_cnt_r;
  sdbsm_dev_st_t       dev_r;
  sdbsm_req_t          req;
  logic                cs_n;
  logic                ras_n;
  logic                cas_n;
  logic                we_n;
  logic                cke;
  logic                rules_on;
  logic                enable;
  logic                all_idle_pulse;
  logic [1:0]          last_burst_r;
  logic [NBANK-1:0]    bank_idle;
  logic                banks_all_idle;
  logic                err_nxt;
  sdbsm_bank_st_t      bst [NBANK];

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, ba_in, 1'b0, addr_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign cke   = pin_s2_r[ADDR_W+7];
  assign cs_n  = pin_s2_r[ADDR_W+6];
  assign ras_n = pin_s2_r[ADDR_W+5];
  assign cas_n = pin_s2_r[ADDR_W+4];
  assign we_n  = pin_s2_r[ADDR_W+3];

  // command decode; inhibit and nop both map to no command
  always_comb begin
    req.bank = pin_s2_r[ADDR_W+2:ADDR_W+1];
    req.ap   = pin_s2_r[AP_BIT];
    if (cs_n) begin
      req.cmd = SDBSM_CMD_NOP;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h3:    req.cmd = SDBSM_CMD_ACT;
        3'h5:    req.cmd = SDBSM_CMD_RD;
        3'h4:    req.cmd = SDBSM_CMD_WR;
        3'h2:    req.cmd = SDBSM_CMD_PRE;
        3'h6:    req.cmd = SDBSM_CMD_BST;
        3'h1:    req.cmd = SDBSM_CMD_REF;
        3'h0:    req.cmd = SDBSM_CMD_LMR;
        default: req.cmd = SDBSM_CMD_NOP;
      endcase
    end
  end

  // clock enable held high two cycles, and txsr served after a low spell
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cke_prev_r <= 1'b0;
      xsr_cnt_r  <= '0;
    end else begin
      cke_prev_r <= cke;
      if (!cke) begin
        xsr_cnt_r <= CNT_W'(XSR_CYC);
      end else if (xsr_cnt_r != '0) begin
        xsr_cnt_r <= xsr_cnt_r - 1'b1;
      end
    end
  end

  assign rules_on = cke && cke_prev_r && (xsr_cnt_r == '0);
  // device-wide states block everything until their time ends
  assign enable   = rules_on && (dev_r == SDBSM_DEV_NORMAL) && (req.cmd != SDBSM_CMD_NOP);

  genvar g;
  generate
    for (g = 0; g < NBANK; g++) begin : g_bank
      assign bank_idle[g] = (bst[g] == SDBSM_BK_IDLE);
      sdbsm_bank #(
        .IDX (g)
      ) u_bank (
        .clk_in      (clk_in),
        .rstn_in     (rstn_in),
        .enable_in   (enable),
        .req_in      (req),
        .all_idle_in (all_idle_pulse),
        .bst_hit_in  (enable && req.cmd == SDBSM_CMD_BST && last_burst_r == 2'(g)),
        .state_out   (bst[g])
      ); // independent state per bank
    end
  endgenerate

  assign banks_all_idle = &bank_idle;
  assign all_idle_pulse = (dev_r != SDBSM_DEV_NORMAL) && (dev_cnt_r == '0);

  // track which bank took the latest read or write
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_burst_r <= '0;
    end else if (enable && (req.cmd == SDBSM_CMD_RD || req.cmd == SDBSM_CMD_WR)) begin
      last_burst_r <= req.bank;
    end
  end

  // device-wide refresh, mode access and precharge-all
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dev_r     <= SDBSM_DEV_NORMAL;
      dev_cnt_r <= '0;
    end else begin
      case (dev_r)
        SDBSM_DEV_NORMAL: begin
          if (enable && req.cmd == SDBSM_CMD_REF && banks_all_idle) begin
            dev_r     <= SDBSM_DEV_REFRESH;
            dev_cnt_r <= CNT_W'(RFC_CYC - 1);
          end else if (enable && req.cmd == SDBSM_CMD_LMR && banks_all_idle) begin
            dev_r     <= SDBSM_DEV_MODE_REG;
            dev_cnt_r <= CNT_W'(T_MRD_CLK - 1);
          end else if (enable && req.cmd == SDBSM_CMD_PRE && req.ap) begin
            dev_r     <= SDBSM_DEV_PRE_ALL;
            dev_cnt_r <= CNT_W'(RP_CYC - 1);
          end
        end
        SDBSM_DEV_REFRESH, SDBSM_DEV_MODE_REG, SDBSM_DEV_PRE_ALL: begin
          if (dev_cnt_r == '0) begin
            dev_r <= SDBSM_DEV_NORMAL;
          end else begin
            dev_cnt_r <= dev_cnt_r - 1'b1;
          end
        end
        default: dev_r <= SDBSM_DEV_NORMAL;
      endcase
    end
  end

  // flag controller slips; no bank changes state on the offending command, yet a read or write refused in the normal device state still sets last_burst_r
  always_comb begin
    err_nxt = 1'b0;
    if (rules_on && req.cmd != SDBSM_CMD_NOP) begin
      if (dev_r != SDBSM_DEV_NORMAL) begin
        err_nxt = 1'b1;
      end else begin
        case (req.cmd)
          SDBSM_CMD_REF, SDBSM_CMD_LMR: err_nxt = !banks_all_idle;
          SDBSM_CMD_ACT: err_nxt = !bank_idle[req.bank];
          SDBSM_CMD_RD, SDBSM_CMD_WR: err_nxt = !(bst[req.bank] == SDBSM_BK_ACTIVE ||
                                                  bst[req.bank] == SDBSM_BK_READ ||
                                                  bst[req.bank] == SDBSM_BK_WRITE);
          SDBSM_CMD_PRE: err_nxt = !req.ap && (bst[req.bank] == SDBSM_BK_ACTIVATING ||
                                               bst[req.bank] == SDBSM_BK_READ_AP ||
                                               bst[req.bank] == SDBSM_BK_WRITE_AP ||
                                               bst[req.bank] == SDBSM_BK_PRECHARGING);
          default: err_nxt = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bank_state_out <= '0;
      dev_state_out  <= SDBSM_DEV_NORMAL;
      all_idle_out   <= 1'b1;
      cmd_error_out  <= 1'b0;
    end else begin
      for (int i = 0; i < NBANK; i++) begin
        bank_state_out[i*3 +: 3] <= bst[i];
      end
      dev_state_out <= dev_r;
      all_idle_out  <= banks_all_idle && (dev_r == SDBSM_DEV_NORMAL);
      cmd_error_out <= err_nxt;
    end
  end
endmodule
`default_nettype wire

// File: verif/sdbsm_top_assertions.sv
// port-level assertions for the sdram bank state machine
`timescale 1ns/10ps
`default_nettype none
module sdbsm_top_assertions
  import sdbsm_pkg::*;
#(
  parameter int NBANK = BANKS
) (
  input wire logic              clk_in,
  input wire logic              rstn_in,
  input wire logic              cke_in,
  input wire logic              cs_n_in,
  input wire logic              ras_n_in,
  input wire logic              cas_n_in,
  input wire logic              we_n_in,
  input wire logic [1:0]        ba_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [NBANK*3-1:0] bank_state_out,
  input wire sdbsm_dev_st_t     dev_state_out,
  input wire logic              all_idle_out,
  input wire logic              cmd_error_out
);
  logic [3:0] hist_r;
  logic [3:0] cke_cnt_r;
  logic       quiet;
  logic       ok;
  // commands still in the sync pipeline would make each relation ambiguous
  assign quiet = (hist_r == 4'h0) && (cke_cnt_r == 4'hF);
  assign ok    = quiet && all_idle_out;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hist_r <= 4'h0;
    end else begin
      hist_r <= {hist_r[2:0], !cs_n_in && !(ras_n_in && cas_n_in && we_n_in)};
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cke_cnt_r <= 4'h0;
    end else begin
      cke_cnt_r <= !cke_in ? 4'h0 : (cke_cnt_r == 4'hF) ? cke_cnt_r : cke_cnt_r + 4'h1;
    end
  end
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  a_inhibit_holds: assert property (ok && cs_n_in |-> ##3 !cmd_error_out ##1 $stable(bank_state_out))
    else $error("state moved after deselect");
  a_nop_holds: assert property (ok && !cs_n_in && ras_n_in && cas_n_in && we_n_in |->
    ##3 !cmd_error_out ##1 $stable(bank_state_out))
    else $error("state moved after nop");
  a_act_opens_row: assert property (ok && !cs_n_in && !ras_n_in && cas_n_in && we_n_in |->
    ##4 (bank_state_out[$past(ba_in, 4)*3 +: 3] == 3'h1) ##2 (bank_state_out[$past(ba_in, 6)*3 +: 3] == 3'h2))
    else $error("activate did not open row in time");
  a_read_idle_refused: assert property (ok && !cs_n_in && ras_n_in && !cas_n_in && we_n_in |-> ##3 cmd_error_out)
    else $error("read to idle bank not refused");
  a_pre_idle_nop: assert property (ok && !cs_n_in && !ras_n_in && cas_n_in && !we_n_in && !addr_in[AP_BIT] |->
    ##3 !cmd_error_out ##1 $stable(bank_state_out))
    else $error("precharge of idle bank had effect");
  a_refresh_span: assert property (ok && !cs_n_in && !ras_n_in && !cas_n_in && we_n_in |->
    ##4 (dev_state_out == SDBSM_DEV_REFRESH) [*6] ##[1:3] all_idle_out)
    else $error("refresh span wrong");
  a_mode_span: assert property (ok && !cs_n_in && !ras_n_in && !cas_n_in && !we_n_in |->
    ##4 (dev_state_out == SDBSM_DEV_MODE_REG) ##[1:3] all_idle_out)
    else $error("mode load span wrong");
  a_pre_all_span: assert property (quiet && dev_state_out == SDBSM_DEV_NORMAL && !cs_n_in && !ras_n_in
    && cas_n_in && !we_n_in && addr_in[AP_BIT] |-> ##4 (dev_state_out == SDBSM_DEV_PRE_ALL) ##[1:4] all_idle_out)
    else $error("precharge all span wrong");
endmodule
bind sdbsm_top sdbsm_top_assertions #(.NBANK(NBANK)) i_chk (.clk_in(clk_in), .rstn_in(rstn_in), .cke_in(cke_in),
  .cs_n_in(cs_n_in), .ras_n_in(ras_n_in), .cas_n_in(cas_n_in), .we_n_in(we_n_in), .ba_in(ba_in), .addr_in(addr_in),
  .bank_state_out(bank_state_out), .dev_state_out(dev_state_out), .all_idle_out(all_idle_out),
  .cmd_error_out(cmd_error_out));
`default_nettype wire

// File: verif/sdbsm_ctrl_model.sv
// controller model: drives the sdram command pins one command at a time
`timescale 1ns/10ps
`default_nettype none
module sdbsm_ctrl_model
  import sdbsm_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              all_idle_in,
  output logic [3:0]             pins_out,
  output logic [1:0]             ba_out,
  output logic [ADDR_W-1:0]      addr_out
);
  initial begin
    pins_out = 4'hF;
    ba_out   = 2'h0;
    addr_out = '0;
  end
  // pins are chip select, row strobe, column strobe, write enable; all low active
  task automatic issue(input logic [3:0] p, input logic [1:0] b, input logic [ADDR_W-1:0] a, input int gap);
    int i;
    if (p == 4'h1 || p == 4'h0) begin
      for (i = 0; i < 100 && all_idle_in !== 1'b1; i++) begin
        @(negedge clk_in);
      end
    end
    @(negedge clk_in);
    pins_out = p;
    ba_out   = b;
    addr_out = a;
    @(negedge clk_in);
    // released command pins fall back to nop and bank and address show the inverse, so a stale value never looks valid
    pins_out = 4'h7;
    ba_out   = ~b;
    addr_out = ~a;
    repeat (gap) @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

// File: verif/test_sdbsm_bank_state_machine.sv
// self-checking bench: commands through the controller model, state changes compared in order
`timescale 1ns/10ps
`default_nettype none
module test_sdbsm_bank_state_machine;
  import sdbsm_pkg::*;
  localparam logic [3:0] P_ACT = 4'h3, P_RD = 4'h5, P_WR = 4'h4, P_PRE = 4'h2;
  localparam logic [3:0] P_BST = 4'h6, P_REF = 4'h1, P_LMR = 4'h0, P_NOP = 4'h7;
  logic              clk_in;
  logic              rstn_in = 1'b0;
  logic              cke_in = 1'b1;
  logic [3:0]        pins;
  logic [1:0]        ba;
  logic [ADDR_W-1:0] addr;
  logic [11:0]       bank_state;
  logic [11:0]       last_st = 12'h000;
  logic [11:0]       exp_v = 12'h000;
  logic [11:0]       want;
  logic [11:0]       exp_q[$];
  sdbsm_dev_st_t     dev_state;
  logic              all_idle;
  logic              cmd_error;
  int                bad_count = 0;
  int                comparisons = 0;
  int                err_seen = 0;
  int                err_exp = 0;
  int                seed = 32'h868C;
  int                k;
  sdbsm_ctrl_model i_ctrl (.clk_in(clk_in), .all_idle_in(all_idle), .pins_out(pins), .ba_out(ba), .addr_out(addr));
  sdbsm_top i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .cke_in(cke_in), .cs_n_in(pins[3]), .ras_n_in(pins[2]),
    .cas_n_in(pins[1]), .we_n_in(pins[0]), .ba_in(ba), .addr_in(addr), .bank_state_out(bank_state),
    .dev_state_out(dev_state), .all_idle_out(all_idle), .cmd_error_out(cmd_error));
  task automatic report_and_stop();
    comparisons++;
    if (err_seen != err_exp || exp_q.size() != 0) begin
      bad_count++;
      $display("CHECK FAILED %0t errors %0h expected %0h", $time, err_seen, err_exp);
    end
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic note(input int b, input logic [2:0] s);
    exp_v[b*3 +: 3] = s;
    exp_q.push_back(exp_v);
  endtask
  // timing checks: the queue alone would accept a late change of state
  task automatic expect_now(input logic [11:0] v);
    comparisons++;
    if (bank_state !== v) begin
      bad_count++;
      $display("CHECK FAILED %0t state %0h expected %0h", $time, bank_state, v);
    end
  endtask
  task automatic go(input logic [3:0] p, input int b, input logic a10, input int gap);
    logic [ADDR_W-1:0] a;
    a = ADDR_W'($random(seed));
    a[AP_BIT] = a10;
    i_ctrl.issue(p, 2'(b), a, gap);
  endtask
  task automatic open_row(input int b);
    note(b, 3'h1);
    note(b, 3'h2);
    go(P_ACT, b, 1'b0, 8);
  endtask
  task automatic access(input int b, input logic wr, input logic ap);
    open_row(b);
    note(b, ap ? (wr ? 3'h6 : 3'h5) : (wr ? 3'h4 : 3'h3));
    note(b, ap ? 3'h0 : 3'h2);
    go(wr ? P_WR : P_RD, b, ap, 16);
    if (!ap) begin
      note(b, 3'h7);
      note(b, 3'h0);
      go(P_PRE, b, 1'b0, 6);
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(negedge clk_in) begin
    if (cmd_error === 1'b1) err_seen++;
    if (rstn_in === 1'b1 && bank_state !== last_st) begin
      want = (exp_q.size() != 0) ? exp_q.pop_front() : last_st;
      comparisons++;
      if (bank_state !== want) begin
        bad_count++;
        $display("CHECK FAILED %0t got %0h expected %0h", $time, bank_state, want);
      end
    end
    last_st <= bank_state;
  end
  initial begin
    repeat (8000) @(posedge clk_in);
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(negedge clk_in);
    rstn_in = 1'b1;
    repeat (16) @(negedge clk_in);
    open_row(1);
    note(1, 3'h3);
    note(1, 3'h4);
    note(1, 3'h2);
    go(P_RD, 1, 1'b0, 2);
    go(P_WR, 1, 1'b0, 8);
    expect_now(12'h020);
    repeat (6) @(negedge clk_in);
    note(1, 3'h4);
    note(1, 3'h2);
    go(P_WR, 1, 1'b0, 2);
    go(P_BST, 2, 1'b0, 3);
    expect_now(12'h010);
    repeat (3) @(negedge clk_in);
    note(1, 3'h3);
    note(1, 3'h7);
    note(1, 3'h0);
    go(P_RD, 1, 1'b0, 2);
    go(P_PRE, 1, 1'b0, 6);
    open_row(2);
    note(2, 3'h4);
    note(2, 3'h7);
    note(2, 3'h0);
    go(P_WR, 2, 1'b0, 2);
    go(P_PRE, 2, 1'b0, 6);
    for (k = 0; k < 4; k++) access(0, k[0], k[1]);
    go(P_PRE, 3, 1'b0, 6);
    go({1'b1, 3'($random(seed))}, 3, 1'b0, 6);
    go(P_NOP, 3, 1'b0, 6);
    go(P_RD, 3, 1'b0, 6);
    err_exp++;
    open_row(3);
    go(P_ACT, 3, 1'b0, 6);
    err_exp++;
    open_row(0);
    open_row(1);
    open_row(2);
    exp_q.push_back(12'hFFF);
    exp_q.push_back(12'h000);
    exp_v = 12'h000;
    go(P_PRE, $random(seed) & 3, 1'b1, 10);
    go(P_REF, 0, 1'b0, 12);
    go(P_LMR, 0, 1'b0, 6);
    go(P_REF, 0, 1'b0, 2);
    go(P_ACT, 1, 1'b0, 12);
    err_exp++;
    cke_in = 1'b0;
    repeat (3) @(negedge clk_in);
    go(P_ACT, 1, 1'b0, 1);
    cke_in = 1'b1;
    repeat (16) @(negedge clk_in);
    repeat (6) access($random(seed) & 3, 1'($random(seed)), 1'($random(seed)));
    repeat (10) @(negedge clk_in);
    report_and_stop();
  end
endmodule
`default_nettype wire
